// file: common/dpssc_defines.svh
// constants for the dp slave status and control block
`ifndef DPSSC_DEFINES_SVH
`define DPSSC_DEFINES_SVH

// global control command byte bit positions
`define DPSSC_GC_BIT_CLEAR    1
`define DPSSC_GC_BIT_UNFREEZE 2
`define DPSSC_GC_BIT_FREEZE   3
`define DPSSC_GC_BIT_UNSYNC   4
`define DPSSC_GC_BIT_SYNC     5
`define DPSSC_GC_CLEAR_POS    1

// reset value and default data width
`define DPSSC_GC_RESET        8'h00
`define DPSSC_DATA_W          8

`endif

// file: common/dpssc_pkg.sv
// types for the dp slave status and control block
package dpssc_pkg;

  // dp state encoding
  typedef enum logic [1:0] {
    state_await_params = 2'b00,
    state_await_config = 2'b01,
    state_exchange     = 2'b10,
    state_fault        = 2'b11
  } dpssc_dp_state_type;

  // decoded global control actions
  typedef struct packed {
    logic clear;
    logic unfreeze;
    logic freeze;
    logic unsync;
    logic sync;
  } dpssc_gc_type;

  // slave address request descriptor
  typedef struct packed {
    logic [7:0] buf_ptr;
    logic [7:0] len;
  } dpssc_ssa_type;

endpackage : dpssc_pkg

// file: hw/dpssc_gc_decode.sv
// decoder of the global control command byte
`include "dpssc_defines.svh"
module dpssc_gc_decode (
  // command byte
  input  wire logic [7:0]          i_cmd,
  // decoded actions
  output dpssc_pkg::dpssc_gc_type  o_act
);
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  // bits 0, 6 and 7 are never looked at
  always_comb begin
    o_act.clear    = i_cmd[`DPSSC_GC_CLEAR_POS];
    o_act.unfreeze = i_cmd[`DPSSC_GC_BIT_UNFREEZE];
    o_act.freeze   = i_cmd[`DPSSC_GC_BIT_FREEZE];
    o_act.unsync   = i_cmd[`DPSSC_GC_BIT_UNSYNC];
    o_act.sync     = i_cmd[`DPSSC_GC_BIT_SYNC];
  end
endmodule : dpssc_gc_decode

// file: hw/dpssc_top.sv
// status and control logic of a dp slave seen from the local processor
//
// Behaviour
// - diag release only after master fetch
// - diag flag true until buffer sent
// - static diagnostics forces flag not sent
// - sent event only when enabled
// - address change event with pointer, length
// - gc event on group match, changed byte
// - gc buffer actions internal, byte readable
// - bit 1 clears output data
// - bit 2 ends input freeze
// - bit 3 freezes inputs
// - bit 4 ends output sync
// - bit 5 releases latest outputs, holds
// - bits 0, 6, 7 trigger no action
// - event on entering or leaving exchange
// - state reported as four codes
// - bad params in exchange leave exchange
// - offline until fresh initialisation
// - passive reads 1, offline 0
`include "dpssc_defines.svh"
module dpssc_top #(
  parameter int DATA_W = `DPSSC_DATA_W
) (
  // clock and reset
  input  wire logic                              i_clk_sys,
  input  wire logic                              i_rst,
  // local side controls
  input  wire logic                              i_init,
  input  wire logic                              i_go_offline_cmd,
  input  wire logic                              i_diag_handover,
  input  wire logic                              i_static_diag,
  input  wire logic                              i_diag_sent_enable,
  input  wire logic                              i_address_buffer_release,
  // master side events
  input  wire logic                              i_diag_fetched,
  input  wire logic                              i_ssa_recv,
  input  wire dpssc_pkg::dpssc_ssa_type          i_ssa,
  input  wire logic                              i_gc_recv,
  input  wire logic                              i_gc_group_match,
  input  wire logic [7:0]                        i_gc_cmd,
  input  wire logic                              i_prm_ok,
  input  wire logic                              i_prm_bad,
  input  wire logic                              i_cfg_ok,
  input  wire logic                              i_fault,
  // data paths
  input  wire logic [DATA_W-1:0]                 i_out_data,
  input  wire logic                              i_out_valid,
  input  wire logic [DATA_W-1:0]                 i_in_data,
  // status to local side
  output logic                                   o_diag_pending_flag,
  output logic                                   o_diag_buf_swap,
  output logic                                   o_diag_sent_event,
  output logic                                   o_address_change_event,
  output dpssc_pkg::dpssc_ssa_type               o_slave_address_request,
  output logic                                   o_ssa_buf_busy,
  output logic                                   o_gc_event,
  output logic [7:0]                             o_gc_cmd,
  output logic                                   o_exchange_state_change_event,
  output dpssc_pkg::dpssc_dp_state_type          o_dp_state,
  output logic                                   o_offline_passive_status,
  // data to application and master
  output logic [DATA_W-1:0]                      o_app_out_data,
  output logic [DATA_W-1:0]                      o_master_in_data
);

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  // command and address fields stay byte wide whatever DATA_W is
  if (DATA_W < 1) begin : g_bad_width
    $error("data width must be at least one bit");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    // diagnostics
    logic                           diag_pend;
    logic                           diag_flag;   // pending or static, as the local side reads it
    logic                           diag_swap;
    logic                           diag_ev;
    // address request
    logic                           ssa_ev;
    dpssc_pkg::dpssc_ssa_type       slave_address_request;
    logic                           ssa_busy;
    // global control
    logic                           gc_ev;
    logic [7:0]                     gc_cmd;
    logic                           frozen;
    logic                           synced;
    // state machine
    logic                           xchg_ev;
    dpssc_pkg::dpssc_dp_state_type  dp_state;
    logic                           passive;
    // data paths
    logic [DATA_W-1:0]              out_latest;
    logic [DATA_W-1:0]              app_out;
    logic [DATA_W-1:0]              master_in;
  } dpssc_state_type;

  // registered state, its next value, decoded command and its strobe
  dpssc_state_type          s_q;
  dpssc_state_type          s_d;
  dpssc_pkg::dpssc_gc_type  gc_act;
  logic                     gc_take;

  // ------------------------------------------------------------
  // command decoder
  // ------------------------------------------------------------
  dpssc_gc_decode u_gc_decode (
    .i_cmd (i_gc_cmd),
    .o_act (gc_act)
  );

  // new message only on group match and a changed byte; a master that
  // repeats the same command every cycle therefore raises no event, and
  // an offline slave takes no command until it is initialised again
  assign gc_take = i_gc_recv && i_gc_group_match && (i_gc_cmd != s_q.gc_cmd) && s_q.passive;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // true while the slave sits in data exchange
  function automatic logic is_exch(input dpssc_pkg::dpssc_dp_state_type st);
    return st == dpssc_pkg::state_exchange;
  endfunction : is_exch

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.diag_ev = 1'b0;
    s_d.ssa_ev  = 1'b0;
    s_d.gc_ev   = 1'b0;
    s_d.xchg_ev = 1'b0;

    // diagnostics: handover arms, master fetch releases the other buffer
    // handover wins over a fetch in the same cycle: the new buffer is not out yet
    s_d.diag_swap = 1'b0;
    if (i_diag_handover) begin
      s_d.diag_pend = 1'b1;
    end else if (s_q.diag_pend && i_diag_fetched) begin
      s_d.diag_pend = 1'b0;
      s_d.diag_swap = 1'b1;
      s_d.diag_ev   = i_diag_sent_enable;
    end

    // flag reads not sent while static diagnostics is on
    s_d.diag_flag = s_d.diag_pend | i_static_diag;

    // address change: a busy buffer refuses a new request
    // pointer and length stand until the next accepted request
    if (i_address_buffer_release) begin
      s_d.ssa_busy = 1'b0;
    end
    if (i_ssa_recv && !s_q.ssa_busy && s_q.passive) begin
      s_d.ssa_ev   = 1'b1;
      s_d.slave_address_request      = i_ssa;
      s_d.ssa_busy = 1'b1;                                   // set wins over release
    end

    // global control handled in hardware
    // unfreeze before freeze and unsync before sync, clear last
    if (gc_take) begin
      s_d.gc_ev  = 1'b1;
      s_d.gc_cmd = i_gc_cmd;
      if (gc_act.unfreeze) begin
        s_d.frozen = 1'b0;
      end
      if (gc_act.freeze) begin
        s_d.frozen = 1'b1;
        s_d.master_in = i_in_data;                           // each freeze takes one fresh snapshot
      end
      if (gc_act.unsync) begin
        s_d.synced = 1'b0;
      end
      if (gc_act.sync) begin
        s_d.synced  = 1'b1;
        s_d.app_out = s_q.out_latest;
      end
      if (gc_act.clear) begin
        s_d.out_latest = '0;
        s_d.app_out    = '0;
      end
    end

    // output data path, held back while synced
    // a clear in the same cycle beats the incoming frame
    if (i_out_valid && !(gc_take && gc_act.clear)) begin
      s_d.out_latest = i_out_data;
      if (!s_q.synced && !(gc_take && gc_act.sync)) begin
        s_d.app_out = i_out_data;
      end
    end

    // input data path, held while frozen
    // the freeze cycle itself already loaded the snapshot above
    if (!s_q.frozen && !(gc_take && gc_act.freeze)) begin
      s_d.master_in = i_in_data;
    end

    // dp state machine
    // a bad parameter frame throws back exchange, and await config unless i_cfg_ok; fault wins over the steps, go offline and init win over fault
    case (s_q.dp_state)
      dpssc_pkg::state_await_params: begin
        if (i_prm_ok) begin
          s_d.dp_state = dpssc_pkg::state_await_config;
        end
      end
      dpssc_pkg::state_await_config: begin
        if (i_cfg_ok) begin
          s_d.dp_state = dpssc_pkg::state_exchange;
        end else if (i_prm_bad) begin
          s_d.dp_state = dpssc_pkg::state_await_params;
        end
      end
      dpssc_pkg::state_exchange: begin
        if (i_prm_bad) begin
          s_d.dp_state = dpssc_pkg::state_await_params;
        end
      end
      // a fresh parameter frame clears the fault
      dpssc_pkg::state_fault: begin
        if (i_prm_ok) begin
          s_d.dp_state = dpssc_pkg::state_await_config;
        end
      end
      // all four codes are used; kept for a clean default
      default: begin
        s_d.dp_state = dpssc_pkg::state_await_params;
      end
    endcase
    if (i_fault) begin
      s_d.dp_state = dpssc_pkg::state_fault;
    end

    // offline: only a fresh initialisation brings the slave back
    // go offline wins over init in the same cycle
    if (i_go_offline_cmd) begin
      s_d.passive  = 1'b0;
      s_d.dp_state = dpssc_pkg::state_await_params;
    end else if (i_init) begin
      s_d.passive  = 1'b1;
      s_d.dp_state = dpssc_pkg::state_await_params;
      s_d.frozen   = 1'b0;
      s_d.synced   = 1'b0;
      s_d.gc_cmd   = `DPSSC_GC_RESET;
    end else if (!s_q.passive) begin
      s_d.dp_state = dpssc_pkg::state_await_params;
    end

    // entering or leaving data exchange
    s_d.xchg_ev = is_exch(s_q.dp_state) != is_exch(s_d.dp_state);
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // synchronous reset; passive idle, not offline, is the start state
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s_q          <= '0;
      s_q.gc_cmd   <= `DPSSC_GC_RESET;
      s_q.frozen   <= 1'b0;
      s_q.synced   <= 1'b0;
      s_q.passive  <= 1'b1;
      s_q.dp_state <= dpssc_pkg::state_await_params;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // outputs, all from flip-flops
  // ------------------------------------------------------------
  // diagnostics
  assign o_diag_pending_flag           = s_q.diag_flag;
  assign o_diag_buf_swap               = s_q.diag_swap;
  assign o_diag_sent_event             = s_q.diag_ev;
  // address request
  assign o_address_change_event        = s_q.ssa_ev;
  assign o_slave_address_request       = s_q.slave_address_request;
  assign o_ssa_buf_busy                = s_q.ssa_busy;
  // global control and state
  assign o_gc_event                    = s_q.gc_ev;
  assign o_gc_cmd                      = s_q.gc_cmd;
  assign o_exchange_state_change_event = s_q.xchg_ev;
  assign o_dp_state                    = s_q.dp_state;
  assign o_offline_passive_status      = s_q.passive;
  // data
  assign o_app_out_data                = s_q.app_out;
  assign o_master_in_data              = s_q.master_in;

endmodule : dpssc_top

// file: tb/dpssc_mstr_model.sv
// behavioural dp master driving the master-side event inputs
module dpssc_mstr_model (
  // clock
  input  wire logic                i_clk_sys,
  // master events and data
  output logic                     o_diag_fetched,
  output logic                     o_ssa_recv,
  output dpssc_pkg::dpssc_ssa_type o_ssa,
  output logic                     o_gc_recv,
  output logic                     o_gc_match,
  output logic [7:0]               o_gc_cmd,
  output logic                     o_prm_ok,
  output logic                     o_prm_bad,
  output logic                     o_cfg_ok,
  output logic                     o_fault,
  output logic [7:0]               o_out_data,
  output logic                     o_out_valid
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // one-cycle strobes, launched just after an edge
  // ----------------------------------------
  initial begin
    {o_diag_fetched, o_ssa_recv, o_ssa, o_gc_recv, o_gc_match, o_gc_cmd} = '0;
    {o_prm_ok, o_prm_bad, o_cfg_ok, o_fault, o_out_data, o_out_valid} = '0;
  end
  task automatic edge1;
    @(posedge i_clk_sys);
    #1;
  endtask : edge1
  // released bytes are inverted so a stale value is never mistaken for data
  task automatic gc(input logic m, input logic [7:0] c);
    edge1;
    {o_gc_recv, o_gc_match, o_gc_cmd} = {1'b1, m, c};
    edge1;
    {o_gc_recv, o_gc_cmd} = {1'b0, ~c};
  endtask : gc
  task automatic slave_address_request(input logic [7:0] p, input logic [7:0] l);
    edge1;
    {o_ssa_recv, o_ssa} = {1'b1, p, l};
    edge1;
    {o_ssa_recv, o_ssa} = {1'b0, ~p, ~l};
  endtask : slave_address_request
  // fetch of the diagnostics buffer by the master
  task automatic fetch;
    edge1;
    o_diag_fetched = 1'b1;
    edge1;
    o_diag_fetched = 1'b0;
  endtask : fetch
  task automatic proto(input int k);
    edge1;
    {o_fault, o_cfg_ok, o_prm_bad, o_prm_ok} = 4'h1 << k;
    edge1;
    {o_fault, o_cfg_ok, o_prm_bad, o_prm_ok} = 4'h0;
  endtask : proto
  task automatic outd(input logic [7:0] d);
    edge1;
    {o_out_valid, o_out_data} = {1'b1, d};
    edge1;
    {o_out_valid, o_out_data} = {1'b0, ~d};
  endtask : outd
endmodule : dpssc_mstr_model

// file: tb/dpssc_top_chk.sv
// concurrent checks on the dp slave status and control ports
module dpssc_chk (
  // clock, reset and inputs
  input wire logic                          i_clk_sys,
  input wire logic                          i_rst,
  input wire logic                          i_init,
  input wire logic                          i_go_offline_cmd,
  input wire logic                          i_static_diag,
  input wire logic                          i_diag_sent_enable,
  input wire logic                          i_ssa_recv,
  input wire dpssc_pkg::dpssc_ssa_type      i_ssa,
  input wire logic                          i_gc_recv,
  input wire logic                          i_gc_group_match,
  input wire logic [7:0]                    i_gc_cmd,
  input wire logic                          i_prm_bad,
  input wire logic                          i_fault,
  // outputs
  input wire logic                          o_diag_pending_flag,
  input wire logic                          o_diag_sent_event,
  input wire logic                          o_address_change_event,
  input wire dpssc_pkg::dpssc_ssa_type      o_slave_address_request,
  input wire logic                          o_ssa_buf_busy,
  input wire logic                          o_gc_event,
  input wire logic [7:0]                    o_gc_cmd,
  input wire logic                          o_exchange_state_change_event,
  input wire dpssc_pkg::dpssc_dp_state_type o_dp_state,
  input wire logic                          o_offline_passive_status
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // properties, all in the system clock domain
  // ----------------------------------------
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  AST_GC_EVT: assert property (i_gc_recv && i_gc_group_match && i_gc_cmd != o_gc_cmd && o_offline_passive_status
    && !i_init && !i_go_offline_cmd |=> o_gc_event && o_gc_cmd == $past(i_gc_cmd)) else $error("gc event missing");
  AST_GC_NOMATCH: assert property (i_gc_recv && !i_gc_group_match |=> !o_gc_event)
    else $error("gc event without group match");
  AST_STATIC: assert property (i_static_diag |=> o_diag_pending_flag) else $error("static diag flag low");
  AST_SENT_EN: assert property (o_diag_sent_event |-> $past(i_diag_sent_enable))
    else $error("sent event while disabled");
  AST_ADDR: assert property (i_ssa_recv && !o_ssa_buf_busy && o_offline_passive_status && !i_go_offline_cmd
    |=> o_address_change_event && o_slave_address_request == $past(i_ssa)) else $error("address request lost");
  AST_XCHG: assert property ((o_dp_state == dpssc_pkg::state_exchange) != ($past(o_dp_state) == dpssc_pkg::state_exchange)
    |-> o_exchange_state_change_event) else $error("exchange change not flagged");
  AST_PRM_BAD: assert property (o_dp_state == dpssc_pkg::state_exchange && i_prm_bad && !i_fault
    |=> o_dp_state == dpssc_pkg::state_await_params) else $error("bad params kept exchange");
  AST_OFF_HOLD: assert property (i_go_offline_cmd or (!o_offline_passive_status && !i_init)
    |=> !o_offline_passive_status) else $error("offline left without init");
  AST_RST: assert property ($past(i_rst) |-> o_gc_cmd == 8'h00 && o_offline_passive_status)
    else $error("bad values after reset");

  // main scenarios reached
  cover property (o_gc_event);
  cover property (o_address_change_event);
  cover property (o_exchange_state_change_event && o_dp_state == dpssc_pkg::state_exchange);
endmodule : dpssc_chk

// file: tb/dpssc_top_test.sv
// self-checking bench for the dp slave status and control block
module dpssc_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic                          i_clk_sys, i_rst, i_static_diag, i_diag_sent_enable, i_diag_fetched, i_ssa_recv;
  logic                          i_gc_recv, i_gc_group_match, i_out_valid, o_diag_pending_flag, o_diag_buf_swap;
  logic                          o_diag_sent_event, o_address_change_event, o_ssa_buf_busy, o_gc_event;
  logic                          o_exchange_state_change_event, o_offline_passive_status;
  logic                          i_init, i_go_offline_cmd, i_diag_handover, i_address_buffer_release;
  logic                          i_prm_ok, i_prm_bad, i_cfg_ok, i_fault;
  logic [7:0]                    i_gc_cmd, i_out_data, i_in_data, o_gc_cmd, o_app_out_data, o_master_in_data;
  dpssc_pkg::dpssc_ssa_type      i_ssa, o_slave_address_request;
  dpssc_pkg::dpssc_dp_state_type o_dp_state;
  int                            error_cnt = 0;
  int                            checks = 0;

  // ----------------------------------------
  // design, master model, clock
  // ----------------------------------------
  dpssc_top uut (.i_clk_sys, .i_rst, .i_init, .i_go_offline_cmd, .i_diag_handover, .i_static_diag,
    .i_diag_sent_enable, .i_address_buffer_release, .i_diag_fetched, .i_ssa_recv, .i_ssa, .i_gc_recv,
    .i_gc_group_match, .i_gc_cmd, .i_prm_ok, .i_prm_bad, .i_cfg_ok, .i_fault, .i_out_data, .i_out_valid,
    .i_in_data, .o_diag_pending_flag, .o_diag_buf_swap, .o_diag_sent_event, .o_address_change_event,
    .o_slave_address_request, .o_ssa_buf_busy, .o_gc_event, .o_gc_cmd, .o_exchange_state_change_event,
    .o_dp_state, .o_offline_passive_status, .o_app_out_data, .o_master_in_data);
  dpssc_mstr_model mm (.i_clk_sys, .o_diag_fetched(i_diag_fetched), .o_ssa_recv(i_ssa_recv), .o_ssa(i_ssa),
    .o_gc_recv(i_gc_recv), .o_gc_match(i_gc_group_match), .o_gc_cmd(i_gc_cmd), .o_prm_ok(i_prm_ok),
    .o_prm_bad(i_prm_bad), .o_cfg_ok(i_cfg_ok), .o_fault(i_fault), .o_out_data(i_out_data),
    .o_out_valid(i_out_valid));
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // local strobe, one cycle wide
  task automatic lp(input int k);
    mm.edge1;
    case (k)
      0: i_address_buffer_release = 1'b1;
      1: i_go_offline_cmd = 1'b1;
      2: i_diag_handover = 1'b1;
      default: i_init = 1'b1;
    endcase
    mm.edge1;
    {i_init, i_go_offline_cmd, i_diag_handover, i_address_buffer_release} = 4'h0;
  endtask : lp
  task automatic wrap_up;
    $display("errors %0d, checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_state;
    chk({o_offline_passive_status, o_gc_cmd, o_dp_state}, {1'b1, 8'h00, 2'b00});
    mm.proto(0);
    chk(o_dp_state, dpssc_pkg::state_await_config);
    mm.proto(2);
    chk({o_exchange_state_change_event, o_dp_state}, {1'b1, dpssc_pkg::state_exchange});
    mm.proto(1);
    chk({o_exchange_state_change_event, o_dp_state}, {1'b1, dpssc_pkg::state_await_params});
    mm.proto(3);
    chk(o_dp_state, dpssc_pkg::state_fault);
    mm.proto(0);
    chk(o_dp_state, dpssc_pkg::state_await_config);
  endtask : t_state
  task automatic t_diag;
    i_diag_sent_enable = 1'b1;
    lp(2);
    chk({o_diag_pending_flag, o_diag_buf_swap}, 2'b10);
    mm.fetch;
    chk({o_diag_pending_flag, o_diag_sent_event, o_diag_buf_swap}, 3'b011);
    i_diag_sent_enable = 1'b0;
    lp(2);
    mm.fetch;
    chk(o_diag_sent_event, 1'b0);
    i_static_diag = 1'b1;
    mm.edge1;
    chk(o_diag_pending_flag, 1'b1);
    i_static_diag = 1'b0;
  endtask : t_diag
  // second request while busy must be ignored until released
  task automatic t_ssa;
    mm.slave_address_request(8'h40, 8'h04);
    chk({o_address_change_event, o_ssa_buf_busy, o_slave_address_request}, {2'b11, 16'h4004});
    mm.slave_address_request(8'h41, 8'h05);
    chk({o_address_change_event, o_slave_address_request}, {1'b0, 16'h4004});
    lp(0);
    chk(o_ssa_buf_busy, 1'b0);
  endtask : t_ssa
  task automatic t_gc;
    mm.outd(8'h5A);
    mm.gc(1'b1, 8'h20);
    chk({o_gc_event, o_gc_cmd, o_app_out_data}, {1'b1, 8'h20, 8'h5A});
    mm.outd(8'hC3);
    chk(o_app_out_data, 8'h5A);
    mm.gc(1'b1, 8'h20);
    chk(o_gc_event, 1'b0);
    mm.gc(1'b0, 8'h10);
    chk(o_gc_event, 1'b0);
    mm.gc(1'b1, 8'h10);
    mm.outd(8'h3C);
    chk(o_app_out_data, 8'h3C);
    i_in_data = 8'h11;
    mm.gc(1'b1, 8'h08);
    i_in_data = 8'h22;
    repeat (2) mm.edge1;
    chk(o_master_in_data, 8'h11);
    mm.gc(1'b1, 8'h04);
    mm.edge1;
    chk(o_master_in_data, 8'h22);
    mm.gc(1'b1, 8'h02);
    chk({o_gc_event, o_app_out_data}, {1'b1, 8'h00});
    mm.gc(1'b1, 8'hC1);
    mm.outd(8'h77);
    chk({o_gc_cmd, o_app_out_data, o_master_in_data}, {8'hC1, 8'h77, 8'h22});
  endtask : t_gc
  task automatic t_off;
    lp(1);
    chk({o_offline_passive_status, o_dp_state}, 3'b000);
    mm.gc(1'b1, 8'h30);
    chk(o_gc_event, 1'b0);
    lp(3);
    chk({o_offline_passive_status, o_gc_cmd}, {1'b1, 8'h00});
  endtask : t_off

  // main sequence and watchdog
  initial begin
    {i_rst, i_init, i_go_offline_cmd, i_diag_handover, i_address_buffer_release} = 5'h10;
    {i_static_diag, i_diag_sent_enable, i_in_data} = 10'h000;
    repeat (16) @(posedge i_clk_sys);
    #1 i_rst = 1'b0;
    t_state;
    t_diag;
    t_ssa;
    t_gc;
    t_off;
    wrap_up;
  end
  initial begin
    #20000;
    error_cnt++;
    wrap_up;
  end
endmodule : dpssc_top_test

bind dpssc_top dpssc_chk chk_i (.i_clk_sys, .i_rst, .i_init, .i_go_offline_cmd, .i_static_diag, .i_diag_sent_enable,
  .i_ssa_recv, .i_ssa, .i_gc_recv, .i_gc_group_match, .i_gc_cmd, .i_prm_bad, .i_fault, .o_diag_pending_flag,
  .o_diag_sent_event, .o_address_change_event, .o_slave_address_request, .o_ssa_buf_busy, .o_gc_event, .o_gc_cmd,
  .o_exchange_state_change_event, .o_dp_state, .o_offline_passive_status);
